// >>> video_out_defs.svh
`ifndef VIDEO_OUT_DEFS_SVH
`define VIDEO_OUT_DEFS_SVH
`define OFS_CTRL     12'h000
`define OFS_DELAY    12'h004
`define OFS_STATUS   12'h008
`define OFS_LINELEN  12'h00C
`define CTRL_EN      0
`define CTRL_DEPTH   2:1
`define CTRL_MODEL   4:3
`define CTRL_BIN     5
`define CTRL_CLK80   6
`define CTRL_RST     32'h0000_0000
`define DELAY_RST    16'h0010
`define LEN_2K       14'h0800
`define RESP_OKAY    2'h0
`define RESP_SLVERR  2'h2
`endif

// >>> video_out_pkg.sv
package video_out_pkg;
    typedef enum logic [1:0]
    {
        ST_IDLE = 2'b00,
        ST_WAIT = 2'b01,
        ST_SEND = 2'b10
    } state_t;
    typedef enum logic [1:0]
    {
        DEPTH_12 = 2'b00,
        DEPTH_10 = 2'b01,
        DEPTH_8  = 2'b10
    } depth_t;
endpackage

// >>> two_tap_line_video_output.sv
// Register access over AXI4-Lite and the placing of the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "video_out_defs.svh"
module two_tap_line_video_output
    import video_out_pkg::*;
(
    // clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // axi4-lite write
    input  wire logic [11:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // axi4-lite read
    input  wire logic [11:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // sensor readout side
    input  wire logic        readout_done,
    output logic [11:0]      pair_addr,
    input  wire logic [23:0] pair_data,
    // pixel clock from the link clock source
    input  wire logic        pixel_clk,
    output logic             pclk_sel_80,
    // transmitter inputs
    output logic [7:0]       port_a,
    output logic [7:0]       port_b,
    output logic [7:0]       port_c,
    output logic             line_valid,
    output logic             data_valid,
    output logic             frame_valid,
    output logic             spare,
    output logic             strobe
);

    // ************************************************
    // lane mapping
    // ************************************************
    function automatic logic [23:0] map_lanes(input logic [11:0] s0,
                                              input logic [11:0] s1,
                                              input depth_t      dep);
        logic [9:0] t0;
        logic [9:0] t1;
        t0 = s0[11:2];
        t1 = s1[11:2];
        case (dep)
            DEPTH_12:
                map_lanes = {s1[7:0], s1[11:8], s0[11:8], s0[7:0]};
            DEPTH_10:
                map_lanes = {t1[7:0], 2'h0, t1[9:8], 2'h0, t0[9:8],
                             t0[7:0]};
            DEPTH_8:
                map_lanes = {8'h00, s1[11:4], s0[11:4]};
            default:
                map_lanes = 24'h00_0000;
        endcase
    endfunction

    // ************************************************
    // register bus
    // ************************************************
    logic [31:0] ctrl_q;
    logic [15:0] delay_q;
    logic        overrun_q;
    logic [11:0] awaddr_q;
    logic        aw_held_q;
    logic [31:0] wdata_q;
    logic [3:0]  wstrb_q;
    logic        w_held_q;
    logic        bvalid_q;
    logic [1:0]  bresp_q;
    logic        rvalid_q;
    logic [1:0]  rresp_q;
    logic [31:0] rdata_q;
    state_t      state_q;
    logic [13:0] len_now;
    logic [12:0] pairs_q;
    logic [12:0] sent_q;

    wire        do_write = aw_held_q && w_held_q && !bvalid_q;
    wire        wr_ctrl  = do_write && (awaddr_q == `OFS_CTRL);
    wire        wr_delay = do_write && (awaddr_q == `OFS_DELAY);
    wire        wr_stat  = do_write && (awaddr_q == `OFS_STATUS);
    wire        wr_hit   = wr_ctrl || wr_delay || wr_stat
                           || (awaddr_q == `OFS_LINELEN);
    wire        rd_take  = s_axi_arvalid && !rvalid_q;
    wire [31:0] ctrl_d;
    wire [31:0] rd_mux;
    wire        rd_hit;

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++)
        begin : g_lane
            assign ctrl_d[gi*8 +: 8] = wstrb_q[gi] ? wdata_q[gi*8 +: 8]
                                                   : ctrl_q[gi*8 +: 8];
        end
    endgenerate

    // line length by model, halved under binning
    assign len_now = ctrl_q[`CTRL_BIN] ?
                     14'(`LEN_2K << ctrl_q[`CTRL_MODEL]) >> 1
                   : 14'(`LEN_2K << ctrl_q[`CTRL_MODEL]);
    assign rd_hit  = (s_axi_araddr == `OFS_CTRL)
                  || (s_axi_araddr == `OFS_DELAY)
                  || (s_axi_araddr == `OFS_STATUS)
                  || (s_axi_araddr == `OFS_LINELEN);
    assign rd_mux  = (s_axi_araddr == `OFS_CTRL)   ? ctrl_q
                   : (s_axi_araddr == `OFS_DELAY)  ? {16'h0000, delay_q}
                   : (s_axi_araddr == `OFS_STATUS) ?
                       {16'h0000, overrun_q, sent_q, state_q}
                   : (s_axi_araddr == `OFS_LINELEN) ? {18'h0_0000, len_now}
                   : 32'h0000_0000;

    assign s_axi_awready = !aw_held_q;
    assign s_axi_wready  = !w_held_q;
    assign s_axi_bvalid  = bvalid_q;
    assign s_axi_bresp   = bresp_q;
    assign s_axi_arready = !rvalid_q;
    assign s_axi_rvalid  = rvalid_q;
    assign s_axi_rresp   = rresp_q;
    assign s_axi_rdata   = rdata_q;
    assign pclk_sel_80   = ctrl_q[`CTRL_CLK80];

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held_q <= 1'b0;
            w_held_q  <= 1'b0;
            awaddr_q  <= 12'h000;
            wdata_q   <= 32'h0000_0000;
            wstrb_q   <= 4'h0;
        end
        else
        begin
            if (s_axi_awvalid && !aw_held_q)
            begin
                aw_held_q <= 1'b1;
                awaddr_q  <= s_axi_awaddr;
            end
            else if (do_write)
                aw_held_q <= 1'b0;
            if (s_axi_wvalid && !w_held_q)
            begin
                w_held_q <= 1'b1;
                wdata_q  <= s_axi_wdata;
                wstrb_q  <= s_axi_wstrb;
            end
            else if (do_write)
                w_held_q <= 1'b0;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            bvalid_q <= 1'b0;
            bresp_q  <= `RESP_OKAY;
            rvalid_q <= 1'b0;
            rresp_q  <= `RESP_OKAY;
            rdata_q  <= 32'h0000_0000;
        end
        else
        begin
            if (do_write)
            begin
                bvalid_q <= 1'b1;
                bresp_q  <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
            end
            else if (s_axi_bready)
                bvalid_q <= 1'b0;
            if (rd_take)
            begin
                rvalid_q <= 1'b1;
                rresp_q  <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
                rdata_q  <= rd_mux;
            end
            else if (s_axi_rready)
                rvalid_q <= 1'b0;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ctrl_q  <= `CTRL_RST;
            delay_q <= `DELAY_RST;
        end
        else
        begin
            if (wr_ctrl)
                ctrl_q <= ctrl_d;
            if (wr_delay)
                delay_q <= ctrl_d[15:0];
        end
    end

    // ************************************************
    // pixel clock sampling
    // ************************************************
    logic pclk_s1_q;
    logic pclk_s2_q;
    logic pclk_s3_q;
    logic pclk_lvl_q;

    // a level counts only once the last two stages agree, so a
    // metastable first stage cannot produce a runt edge
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            pclk_s1_q  <= 1'b0;
            pclk_s2_q  <= 1'b0;
            pclk_s3_q  <= 1'b0;
            pclk_lvl_q <= 1'b0;
        end
        else
        begin
            pclk_s1_q <= pixel_clk;
            pclk_s2_q <= pclk_s1_q;
            pclk_s3_q <= pclk_s2_q;
            if (pclk_s2_q == pclk_s3_q)
                pclk_lvl_q <= pclk_s3_q;
        end
    end

    wire pclk_rise = pclk_s2_q && pclk_s3_q && !pclk_lvl_q;

    // ************************************************
    // line sequencer
    // ************************************************
    logic [15:0] wait_q;
    depth_t      depth_q;
    logic        lval_q;
    logic [23:0] lanes_q;

    wire start    = readout_done && ctrl_q[`CTRL_EN];
    wire last     = (sent_q + 13'h0001) == pairs_q;
    wire wait_end = pclk_rise && (wait_q == 16'h0000);

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            overrun_q <= 1'b0;
        else if (start && state_q != ST_IDLE)
            overrun_q <= 1'b1;
        else if (wr_stat && wstrb_q[1] && wdata_q[15])
            overrun_q <= 1'b0;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            state_q <= ST_IDLE;
            wait_q  <= 16'h0000;
            pairs_q <= 13'h0000;
            sent_q  <= 13'h0000;
            depth_q <= DEPTH_12;
            lval_q  <= 1'b0;
            lanes_q <= 24'h00_0000;
        end
        else
        begin
            case (state_q)
                ST_IDLE:
                begin
                    // depth, line length and delay are frozen for the whole line; pclk_sel_80 is not
                    if (start)
                    begin
                        state_q <= ST_WAIT;
                        wait_q  <= delay_q;
                        pairs_q <= len_now[13:1];
                        depth_q <= depth_t'(ctrl_q[`CTRL_DEPTH]);
                        sent_q  <= 13'h0000;
                    end
                end
                ST_WAIT:
                begin
                    if (wait_end)
                        state_q <= ST_SEND;
                    else if (pclk_rise)
                        wait_q <= wait_q - 16'h0001;
                end
                ST_SEND:
                begin
                    if (pclk_rise)
                    begin
                        if (sent_q == pairs_q)
                        begin
                            lval_q  <= 1'b0;
                            lanes_q <= 24'h00_0000;
                            state_q <= ST_IDLE;
                        end
                        else
                        begin
                            lval_q  <= 1'b1;
                            lanes_q <= map_lanes(pair_data[11:0],
                                                 pair_data[23:12],
                                                 depth_q);
                            sent_q  <= sent_q + 13'h0001;
                        end
                    end
                end
                default:
                    state_q <= ST_IDLE;
            endcase
        end
    end

    // next pair to fetch; readout side answers within one aclk
    assign pair_addr   = sent_q[11:0];
    assign port_a      = lanes_q[7:0];
    assign port_b      = lanes_q[15:8];
    assign port_c      = lanes_q[23:16];
    assign line_valid  = lval_q;
    assign data_valid  = lval_q;
    assign frame_valid = 1'b0;
    assign spare       = 1'b0;
    assign strobe      = pclk_s3_q;

    // ************************************************
    // checks
    // ************************************************
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    AST_IDLE_LOW: assert property (
        state_q == ST_IDLE && $past(state_q) == ST_IDLE |-> !line_valid)
        else $error("flags high while idle");
    AST_FLAGS_PAIR: assert property (
        line_valid == data_valid)
        else $error("line and data valid differ");
    AST_ON_EDGE: assert property (
        $changed(line_valid) |-> $past(pclk_rise))
        else $error("flag moved off a pixel clock edge");
    AST_FIRST: assert property (
        $rose(line_valid) |-> sent_q == 13'h0001)
        else $error("first cycle not pixels 1 and 2");
    AST_LENGTH: assert property (
        $fell(line_valid) |-> $past(sent_q) == $past(pairs_q))
        else $error("line length wrong");
    AST_ADVANCE: assert property (
        line_valid && pclk_rise && !last && sent_q != pairs_q
        |=> line_valid && sent_q == $past(sent_q) + 13'h0001)
        else $error("pair did not advance");
    AST_8BIT: assert property (
        line_valid && depth_q == DEPTH_8 |-> port_c == 8'h00)
        else $error("port c used in 8-bit mode");
    AST_10BIT: assert property (
        line_valid && depth_q == DEPTH_10
        |-> port_b[3:2] == 2'h0 && port_b[7:6] == 2'h0)
        else $error("unused lanes driven in 10-bit mode");
    AST_UNUSED: assert property (
        !frame_valid && !spare)
        else $error("frame valid or spare driven");
    AST_START: assert property (
        state_q == ST_IDLE && start |=> state_q == ST_WAIT && !line_valid)
        else $error("line did not wait for readout");
    COV_12: cover property ($fell(line_valid) && depth_q == DEPTH_12);
    COV_8: cover property ($rose(line_valid) && depth_q == DEPTH_8);
    COV_BIN: cover property ($rose(line_valid) && pairs_q == 13'h0200);

endmodule
`default_nettype wire

// >>> frame_grabber_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// frame grabber at the far end of the link
// ****************************************
module frame_grabber_model
(
    // link lanes as seen at the transmitter inputs
    input  wire logic       aclk,
    input  wire logic       strobe,
    input  wire logic [7:0] port_a,
    input  wire logic [7:0] port_b,
    input  wire logic [7:0] port_c,
    input  wire logic       line_valid,
    input  wire logic       data_valid,
    input  wire logic       frame_valid,
    input  wire logic       spare
);
    logic        strobe_q = 1'b0;
    logic [23:0] got_q[$];
    int          bad      = 0;

    // sample at the falling strobe, half a period clear of any launch
    always @(posedge aclk)
    begin
        strobe_q <= strobe;
        if (strobe_q && !strobe)
        begin
            if (line_valid === 1'b1 && data_valid === 1'b1)
                got_q.push_back({port_c, port_b, port_a});
            if (line_valid !== data_valid || frame_valid !== 1'b0
                || spare !== 1'b0)
                bad++;
        end
    end
endmodule
`default_nettype wire

// >>> test_two_tap_line_video_output.sv
`timescale 1ns/1ps
`default_nettype none
`include "video_out_defs.svh"
module test_two_tap_line_video_output;
    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic [11:0] aw_addr = 12'h000;
    logic        aw_vld = 1'b0;
    logic [31:0] w_data = 32'h0;
    logic        w_vld = 1'b0;
    logic        b_rdy = 1'b0;
    logic [11:0] ar_addr = 12'h000;
    logic        ar_vld = 1'b0;
    logic        r_rdy = 1'b0;
    logic        readout_done = 1'b0;
    logic [23:0] pair_data = 24'h000000;
    logic        pixel_clk = 1'b0;
    wire logic   aw_rdy, w_rdy, b_vld, ar_rdy, r_vld, pclk_sel_80;
    wire logic   line_valid, data_valid, frame_valid, spare, strobe;
    wire logic [1:0]  b_resp, r_resp;
    wire logic [31:0] r_data;
    wire logic [11:0] pair_addr;
    wire logic [7:0]  port_a, port_b, port_c;
    int          error_cnt = 0;
    int          n_checks = 0;
    int          seed = 32'h082A;
    logic [23:0] mem[4096];
    logic [31:0] rd;
    logic [1:0]  rsp;
    int          dly, dmin, dmax, np;
    int          dtab[5] = '{0, 1, 2, 2, 3};
    int          btab[5] = '{1, 1, 1, 0, 1};

    two_tap_line_video_output dut (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(aw_addr), .s_axi_awvalid(aw_vld), .s_axi_awready(aw_rdy),
        .s_axi_wdata(w_data), .s_axi_wstrb(4'hF), .s_axi_wvalid(w_vld),
        .s_axi_wready(w_rdy), .s_axi_bresp(b_resp), .s_axi_bvalid(b_vld),
        .s_axi_bready(b_rdy), .s_axi_araddr(ar_addr), .s_axi_arvalid(ar_vld),
        .s_axi_arready(ar_rdy), .s_axi_rdata(r_data), .s_axi_rresp(r_resp),
        .s_axi_rvalid(r_vld), .s_axi_rready(r_rdy),
        .readout_done(readout_done), .pair_addr(pair_addr),
        .pair_data(pair_data), .pixel_clk(pixel_clk),
        .pclk_sel_80(pclk_sel_80), .port_a(port_a), .port_b(port_b),
        .port_c(port_c), .line_valid(line_valid), .data_valid(data_valid),
        .frame_valid(frame_valid), .spare(spare), .strobe(strobe));
    frame_grabber_model grab (.aclk(aclk), .strobe(strobe), .port_a(port_a),
        .port_b(port_b), .port_c(port_c), .line_valid(line_valid),
        .data_valid(data_valid), .frame_valid(frame_valid), .spare(spare));

    // ****************************************
    // clocks and sensor readout memory
    // ****************************************
    initial forever #2.5 aclk = ~aclk;
    // odd start so no link clock edge falls on an aclk edge
    initial
    begin
        #13.3;
        forever #40 pixel_clk = ~pixel_clk;
    end
    always @(posedge aclk)
        pair_data <= mem[pair_addr];

    // ****************************************
    // checking, bus and line tasks
    // ****************************************
    function automatic logic [23:0] lanes(input logic [23:0] s, input int d);
        logic [11:0] a;
        logic [11:0] b;
        a = s[11:0];
        b = s[23:12];
        // depth code 3 is not a mode: all lanes stay quiet
        if (d == 3)
            return 24'h00_0000;
        if (d == 0)
            return {b[7:0], b[11:8], a[11:8], a[7:0]};
        a = a >> 2;
        b = b >> 2;
        if (d == 1)
            return {b[7:0], 2'b00, b[9:8], 2'b00, a[9:8], a[7:0]};
        return {8'h00, s[23:16], s[11:4]};
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
            error_cnt++;
        end
    endtask

    task automatic close_out();
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic hang();
        error_cnt++;
        close_out();
    endtask

    task automatic axw(input logic [11:0] a, input logic [31:0] d);
        bit done;
        done = 0;
        @(posedge aclk);
        aw_addr <= a;
        aw_vld <= 1'b1;
        w_data <= d;
        w_vld <= 1'b1;
        b_rdy <= 1'b1;
        for (int k = 0; k < 200 && !done; k++)
        begin
            @(posedge aclk);
            if (aw_vld && aw_rdy)
                aw_vld <= 1'b0;
            if (w_vld && w_rdy)
                w_vld <= 1'b0;
            if (b_vld)
            begin
                rsp = b_resp;
                b_rdy <= 1'b0;
                done = 1;
            end
        end
        if (!done)
            hang();
    endtask

    task automatic axr(input logic [11:0] a);
        bit done;
        done = 0;
        @(posedge aclk);
        ar_addr <= a;
        ar_vld <= 1'b1;
        r_rdy <= 1'b1;
        for (int k = 0; k < 200 && !done; k++)
        begin
            @(posedge aclk);
            if (ar_vld && ar_rdy)
                ar_vld <= 1'b0;
            if (r_vld)
            begin
                rd = r_data;
                rsp = r_resp;
                r_rdy <= 1'b0;
                done = 1;
            end
        end
        if (!done)
            hang();
    endtask

    task automatic pulse();
        @(posedge aclk);
        readout_done <= 1'b1;
        @(posedge aclk);
        readout_done <= 1'b0;
    endtask

    task automatic run_line(input int d, input int b);
        int k;
        np = b ? 512 : 1024;
        for (k = 0; k < 4096; k++)
            mem[k] = 24'($random(seed));
        grab.got_q.delete();
        axw(`OFS_CTRL, {25'h0, d[0], b[0], 2'b00, d[1:0], 1'b1});
        chk(32'(pclk_sel_80), 32'(d[0]));
        chk(32'(line_valid), 0);
        pulse();
        for (dly = 0; dly < 2000 && !line_valid; dly++)
            @(posedge aclk);
        if (!line_valid)
            hang();
        chk(32'(dly >= 250), 1);
        // a second start while busy must be ignored and flagged
        if (d == 0)
            pulse();
        for (k = 0; k < 40000 && line_valid; k++)
            @(posedge aclk);
        if (line_valid)
            hang();
        for (k = 0; k < 100 && grab.got_q.size() < np; k++)
            @(posedge aclk);
        chk(grab.got_q.size(), np);
        chk(grab.bad, 0);
        for (k = 0; k < np && k < grab.got_q.size(); k++)
            chk(32'(grab.got_q[k]), 32'(lanes(mem[k], d)));
        axr(`OFS_STATUS);
        chk(rd, (np << 2) | (d == 0 ? 32'h8000 : 0));
        if (d == 0)
            axw(`OFS_STATUS, 32'h0000_8000);
        $display("line test depth %0d binning %0d done", d, b);
    endtask

    // ****************************************
    // main sequence
    // ****************************************
    initial
    begin
        for (int k = 0; k < 4096; k++)
            mem[k] = 24'($random(seed));
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        axr(`OFS_CTRL);
        chk(rd, `CTRL_RST);
        axr(`OFS_DELAY);
        chk(rd, 32'(`DELAY_RST));
        axw(`OFS_LINELEN, 32'h1);
        chk(32'(rsp), 32'(`RESP_OKAY));
        axr(`OFS_LINELEN);
        chk(rd, 32'h800);
        axr(12'h010);
        chk(32'(rsp), 32'(`RESP_SLVERR));
        chk(rd, 0);
        axw(12'h014, 32'h5);
        chk(32'(rsp), 32'(`RESP_SLVERR));
        for (int m = 0; m < 3; m++)
            for (int b = 0; b < 2; b++)
            begin
                axw(`OFS_CTRL, {26'h0, b[0], m[1:0], 3'b000});
                axr(`OFS_LINELEN);
                chk(rd, (2048 << m) >> b);
            end
        $display("register test done");
        dmin = 100000;
        dmax = 0;
        for (int i = 0; i < 5; i++)
        begin
            run_line(dtab[i], btab[i]);
            if (i < 3 && dly < dmin)
                dmin = dly;
            if (i < 3 && dly > dmax)
                dmax = dly;
        end
        chk(32'(dmax - dmin <= 20), 1);
        close_out();
    end
endmodule
`default_nettype wire
